// ### include/pfbi_defs.svh
// Timing and field constants for the parallel flash bus controller.
// Assumes a 250 MHz controller clock; the flash itself is asynchronous.
//
// Function
// - Read: chip select, output gate low, write high
// - Write: write strobe, chip select low, gate high
// - Bypass programming takes two writes, not four; the host issues single bus writes only and has no command sequencer
// - Allow chip select access time after standby
// - Reissue operations cut short by reset; the host does not reissue, it returns to idle after recovery
// - Wait recovery time after reset before reading
// - Word addresses 19:0, byte adds low bit
`ifndef PFBI_DEFS_SVH
`define PFBI_DEFS_SVH

`define PFBI_CLK_MHZ 250
`define PFBI_ACCESS_NS 70
`define PFBI_CS_ACCESS_NS 70
`define PFBI_WRITE_PULSE_NS 35
`define PFBI_WRITE_HIGH_NS 30
`define PFBI_RESET_PULSE_NS 500
`define PFBI_RESET_RECOVERY_NS 50
`define PFBI_READY_NS 20000
`define PFBI_CYC(ns) (((ns) * `PFBI_CLK_MHZ + 999) / 1000)
`define PFBI_ADDR_W 20
`define PFBI_DATA_W 16
`define PFBI_BYTE_W 8
`define PFBI_CNT_W 16
`define PFBI_TOP_BIT 15

`endif

// ### include/pfbi_pkg.sv
// Types shared by the parallel flash bus controller.
// Assumes the constants header is on the include path.
`default_nettype none
package pfbi_pkg;
    typedef enum logic [2:0] {
        PFBI_RESET,
        PFBI_RECOVER,
        PFBI_IDLE,
        PFBI_READ,
        PFBI_WRITE,
        PFBI_WRITE_GAP
    } pfbi_state_t;
endpackage
`default_nettype wire

// ### core/pfbi_sync.sv
// Two-stage synchroniser for one asynchronous pin.
// Assumes a single clock domain; the first stage feeds only the second.
`default_nettype none
module pfbi_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Pin and result
    input wire logic d,
    output logic q
);
    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    always_comb begin
        meta_nxt = ce ? d : meta_r;
        q_nxt = ce ? meta_r : q_r;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RESET_VAL;
            q_r <= RESET_VAL;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// ### core/pfbi_host.sv
// Host controller driving an asynchronous parallel NOR flash over its pins.
// Assumes the flash pins are joined outside; data pins are split in/out/enable.
`include "pfbi_defs.svh"
`default_nettype none
module pfbi_host
    import pfbi_pkg::*;
#(
    parameter int ADDR_W = `PFBI_ADDR_W,
    parameter int READY_CYC = `PFBI_CYC(`PFBI_READY_NS)
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // User request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_reset,
    input wire logic byte_mode,
    input wire logic [ADDR_W:0] req_addr,
    input wire logic [`PFBI_DATA_W-1:0] req_wdata,
    // User answer
    output logic rsp_valid,
    output logic [`PFBI_DATA_W-1:0] rsp_rdata,
    output logic flash_busy,
    // Flash pins
    output logic [ADDR_W-1:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    output logic fl_reset_n,
    output logic fl_byte_n,
    input wire logic [`PFBI_DATA_W-1:0] fl_dq_in,
    output logic [`PFBI_DATA_W-1:0] fl_dq_out,
    output logic [`PFBI_DATA_W-1:0] fl_dq_oe,
    input wire logic ready_busy_out
);
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Sample window adds two cycles for the data synchronisers
    localparam logic [`PFBI_CNT_W-1:0] RD_CYC =
        `PFBI_CNT_W'(`PFBI_CYC(`PFBI_CS_ACCESS_NS) + 2);
    localparam logic [`PFBI_CNT_W-1:0] WP_CYC = `PFBI_CNT_W'(`PFBI_CYC(`PFBI_WRITE_PULSE_NS));
    localparam logic [`PFBI_CNT_W-1:0] WH_CYC = `PFBI_CNT_W'(`PFBI_CYC(`PFBI_WRITE_HIGH_NS));
    localparam logic [`PFBI_CNT_W-1:0] RP_CYC = `PFBI_CNT_W'(`PFBI_CYC(`PFBI_RESET_PULSE_NS));
    localparam logic [`PFBI_CNT_W-1:0] RH_CYC =
        `PFBI_CNT_W'(`PFBI_CYC(`PFBI_RESET_RECOVERY_NS));
    localparam logic [`PFBI_CNT_W-1:0] RDY_CYC = `PFBI_CNT_W'(READY_CYC);

    // Pin map is fixed; the ready count must fit the shared counter
    if (ADDR_W != `PFBI_ADDR_W) begin : g_bad_addr
        $error("pfbi_host: address width must be 20");
    end
    if (READY_CYC < 1 || READY_CYC > (1 << `PFBI_CNT_W) - 1) begin : g_bad_ready
        $error("pfbi_host: ready count out of range");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rb_s;
    logic [`PFBI_DATA_W-1:0] dq_s;

    pfbi_sync #(.RESET_VAL(1'b0)) u_rb (
        .clk(clk), .rst_n(rst_n), .ce(ce), .d(ready_busy_out), .q(rb_s)
    );
    for (genvar g = 0; g < `PFBI_DATA_W; g++) begin : g_dq
        pfbi_sync #(.RESET_VAL(1'b0)) u_dq (
            .clk(clk), .rst_n(rst_n), .ce(ce), .d(fl_dq_in[g]), .q(dq_s[g])
        );
    end

    // ------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------
    pfbi_state_t st_r, st_nxt;
    logic [`PFBI_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [`PFBI_DATA_W-1:0] wdat_r, wdat_nxt;
    logic [`PFBI_DATA_W-1:0] rdat_r, rdat_nxt;
    logic byte_r, byte_nxt;
    logic a_low_r, a_low_nxt;
    logic rsp_r, rsp_nxt;
    logic idle;

    assign idle = (st_r == PFBI_IDLE);

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = (cnt_r != '0) ? cnt_r - `PFBI_CNT_W'(1) : cnt_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        rdat_nxt = rdat_r;
        byte_nxt = byte_r;
        a_low_nxt = a_low_r;
        rsp_nxt = 1'b0;
        unique case (st_r)
            PFBI_RESET: begin
                // Pulse held the minimum width, then busy must clear
                if (cnt_r == '0) begin
                    st_nxt = PFBI_RECOVER;
                    cnt_nxt = RH_CYC + RDY_CYC;
                end
            end
            PFBI_RECOVER: begin
                // Wait out recovery time, then for the ready pin with no time-out on the ready count
                if (cnt_r <= RDY_CYC && rb_s) begin
                    if (cnt_r + RH_CYC <= RDY_CYC + RH_CYC) begin
                        st_nxt = PFBI_IDLE;
                    end
                end
            end
            PFBI_IDLE: begin
                if (req_valid) begin
                    byte_nxt = byte_mode;
                    addr_nxt = byte_mode ? req_addr[ADDR_W:1] : req_addr[ADDR_W-1:0];
                    a_low_nxt = req_addr[0];
                    wdat_nxt = req_wdata;
                    if (req_reset) begin
                        st_nxt = PFBI_RESET;
                        cnt_nxt = RP_CYC;
                    end else if (req_write) begin
                        st_nxt = PFBI_WRITE;
                        cnt_nxt = WP_CYC;
                    end else begin
                        // Full chip-select access also covers wake from standby
                        st_nxt = PFBI_READ;
                        cnt_nxt = RD_CYC;
                    end
                end
            end
            PFBI_READ: begin
                if (cnt_r == '0) begin
                    // Byte mode keeps only the low lane; status and codes live there
                    rdat_nxt = byte_r ? {{`PFBI_BYTE_W{1'b0}}, dq_s[`PFBI_BYTE_W-1:0]} : dq_s;
                    rsp_nxt = 1'b1;
                    st_nxt = PFBI_IDLE;
                end
            end
            PFBI_WRITE: begin
                if (cnt_r == '0) begin
                    st_nxt = PFBI_WRITE_GAP;
                    cnt_nxt = WH_CYC;
                end
            end
            PFBI_WRITE_GAP: begin
                if (cnt_r == '0) begin
                    rsp_nxt = 1'b1;
                    st_nxt = PFBI_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= PFBI_RESET;
            cnt_r <= RP_CYC;
            addr_r <= '0;
            wdat_r <= '0;
            rdat_r <= '0;
            byte_r <= 1'b0;
            a_low_r <= 1'b0;
            rsp_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            rdat_r <= rdat_nxt;
            byte_r <= byte_nxt;
            a_low_r <= a_low_nxt;
            rsp_r <= rsp_nxt;
        end else begin
            rsp_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    // Chip select stays high when idle so the device sits in standby
    logic rd, wr;
    assign rd = (st_r == PFBI_READ);
    assign wr = (st_r == PFBI_WRITE);

    always_comb begin
        fl_addr = addr_r;
        fl_ce_n = !(rd || wr || st_r == PFBI_WRITE_GAP);
        fl_oe_n = !rd;
        fl_we_n = !wr;
        fl_reset_n = (st_r != PFBI_RESET);
        fl_byte_n = !byte_r;
        fl_dq_out = wdat_r;
        fl_dq_oe = '0;
        if (byte_r) begin
            // Top data pin carries the low byte address in byte mode
            fl_dq_out[`PFBI_TOP_BIT] = a_low_r;
            fl_dq_out[`PFBI_TOP_BIT-1:`PFBI_BYTE_W] = '0;
            fl_dq_oe[`PFBI_TOP_BIT] = 1'b1;
            fl_dq_oe[`PFBI_BYTE_W-1:0] = {`PFBI_BYTE_W{wr || st_r == PFBI_WRITE_GAP}};
        end else begin
            fl_dq_oe = {`PFBI_DATA_W{wr || st_r == PFBI_WRITE_GAP}};
        end
    end

    assign req_ready = idle && ce;
    assign rsp_valid = rsp_r;
    assign rsp_rdata = rdat_r;
    assign flash_busy = !rb_s;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    read_strobes_a: assert property (@(posedge clk) disable iff (!rst_n)
        !fl_oe_n |-> (!fl_ce_n && fl_we_n && fl_dq_oe[`PFBI_BYTE_W-1:0] == '0))
        else $error("read strobes wrong");
    write_strobes_a: assert property (@(posedge clk) disable iff (!rst_n)
        !fl_we_n |-> (!fl_ce_n && fl_oe_n))
        else $error("write strobes wrong");
    top_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        fl_byte_n == 1'b0 |-> (fl_dq_oe[`PFBI_TOP_BIT]
            && fl_dq_oe[`PFBI_TOP_BIT-1:`PFBI_BYTE_W] == '0))
        else $error("byte mode lanes wrong");
    reset_width_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && $fell(fl_reset_n) |-> !fl_reset_n [*2])
        else $error("reset pulse too short");
    no_access_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        !fl_reset_n |-> fl_ce_n && fl_oe_n && fl_we_n)
        else $error("access during reset");
    recover_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && $rose(fl_reset_n) |-> req_ready == 1'b0)
        else $error("no recovery wait");
    read_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && $fell(fl_oe_n) |-> ##1 (!fl_oe_n || !ce))
        else $error("read too short");
    word_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
        fl_byte_n && !fl_we_n |-> fl_dq_oe == '1)
        else $error("word write lanes wrong");
endmodule
`default_nettype wire

// ### sim/pfbi_flash_model.sv
// Behavioural parallel flash seen at its pins, for the host bench.
// Assumes the bench resolves the data wires and feeds them back as dq.
`default_nettype none
module pfbi_flash_model #(
    parameter int BUSY_CYC = 200,
    parameter int RST_CYC = 300,
    parameter logic [7:0] STAT = 8'h4C
) (
    // Counter clock
    input wire logic clk,
    // Flash pins
    input wire logic [19:0] fl_addr,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n,
    input wire logic fl_reset_n,
    input wire logic fl_byte_n,
    input wire logic [15:0] dq,
    output logic [15:0] m_dq,
    output logic ready_busy_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [16];
    logic [15:0] word_v, rd_v;
    logic [15:0] last_v = 16'h0000;
    logic we_d = 1'b1;
    logic drive_d = 1'b0;
    logic drive;
    int busy = 0;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = {i[3:0], 4'hA, ~i[3:0], 4'h5};
    end
    always_comb begin
        word_v = mem[fl_addr[3:0]];
        if (busy > 0) rd_v = {~last_v[15:8], STAT};
        else if (!fl_byte_n) rd_v = {~last_v[15:8], dq[15] ? word_v[15:8] : word_v[7:0]};
        else rd_v = word_v;
    end
    // Released lines show the inverse, so a stale value never passes
    assign drive = !fl_ce_n && !fl_oe_n && fl_we_n && fl_reset_n;
    assign #65 m_dq = drive ? rd_v : ~last_v;
    assign ready_busy_out = (busy == 0);
    always @(posedge clk) begin
        we_d <= fl_we_n;
        drive_d <= drive;
        // Floating lanes change only after a read, else the slow output never settles
        if (drive_d && !drive) last_v <= m_dq;
        if (!fl_reset_n && busy > RST_CYC) busy <= RST_CYC;
        else if (busy > 0) busy <= busy - 1;
        // Data latched on the rising write strobe; sector erase is not modelled
        if (fl_reset_n && !fl_ce_n && fl_oe_n && fl_we_n && !we_d && busy == 0) begin
            if (fl_byte_n) mem[fl_addr[3:0]] <= dq;
            else if (dq[15]) mem[fl_addr[3:0]][15:8] <= dq[7:0];
            else mem[fl_addr[3:0]][7:0] <= dq[7:0];
            busy <= BUSY_CYC;
        end
    end
endmodule
`default_nettype wire

// ### sim/pfbi_host_test.sv
// Self-checking bench: flash host controller against the pin-level flash model.
// Assumes design, package and model are compiled first.
`default_nettype none
module pfbi_host_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic req_reset = 1'b0, byte_mode = 1'b0, rd_bad = 1'b0, wr_bad = 1'b0, gap_bad = 1'b0;
    logic [20:0] req_addr = 21'h000000;
    logic [15:0] req_wdata = 16'h0000;
    logic req_ready, rsp_valid, flash_busy, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, fl_byte_n, rbo;
    logic [15:0] rsp_rdata, h_out, h_oe, m_dq, dq;
    logic [19:0] fl_addr;
    logic [15:0] shadow [16];
    logic [31:0] seed = 32'h03389720;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    realtime t_rst = 0;
    assign dq = (h_oe & h_out) | (~h_oe & m_dq);
    pfbi_host #(.READY_CYC(20)) pfbi_host_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
        .req_reset(req_reset), .byte_mode(byte_mode), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .flash_busy(flash_busy), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n), .fl_byte_n(fl_byte_n), .fl_dq_in(dq),
        .fl_dq_out(h_out), .fl_dq_oe(h_oe), .ready_busy_out(rbo));
    pfbi_flash_model pfbi_flash_model_inst (.clk(clk), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n), .fl_byte_n(fl_byte_n),
        .dq(dq), .m_dq(m_dq), .ready_busy_out(rbo));
    initial begin
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // Pin watchers and timeout
    // ----------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fl_oe_n === 1'b0 && (fl_we_n !== 1'b1 || fl_ce_n !== 1'b0)) rd_bad = 1'b1;
        if (fl_we_n === 1'b0 && (fl_oe_n !== 1'b1 || fl_ce_n !== 1'b0)) wr_bad = 1'b1;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop;
        end
    end
    always @(posedge fl_reset_n) t_rst = $realtime;
    always @(negedge fl_oe_n) if ($realtime - t_rst < 50.0) gap_bad = 1'b1;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] exp_rd(input logic [20:0] a, input logic bm);
        logic [15:0] w;
        w = shadow[bm ? a[4:1] : a[3:0]];
        return bm ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w;
    endfunction
    task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_data({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic wait_busy(input logic lvl, input int lim);
        for (int n = 0; n < lim && flash_busy !== lvl; n++) @(posedge clk) #1;
    endtask
    // Held until the edge that takes it; rsp_valid lasts one cycle
    task automatic access(input logic wr, input logic rs, input logic bm, input logic [20:0] a,
        input logic [15:0] d, output logic [15:0] q);
        int n;
        {req_write, req_reset, byte_mode, req_addr, req_wdata} = {wr, rs, bm, a, d};
        req_valid = 1'b1;
        for (n = 0; n < 3000 && req_ready !== 1'b1; n++) @(posedge clk) #1;
        @(posedge clk) #1;
        req_valid = 1'b0;
        for (n = 0; n < 100 && !rs && rsp_valid !== 1'b1; n++) @(posedge clk) #1;
        // A reset has no answer; let an edge pass before the next request
        if (rs) @(posedge clk) #1;
        q = rsp_rdata;
        if (wr) begin
            if (!bm) shadow[a[3:0]] = d;
            else if (a[0]) shadow[a[4:1]][15:8] = d[7:0];
            else shadow[a[4:1]][7:0] = d[7:0];
        end
    endtask
    task automatic program_check(input logic bm, input logic [20:0] a, input logic [15:0] d);
        logic [15:0] q;
        access(1'b1, 1'b0, bm, a, d, q);
        wait_busy(1'b1, 20);
        cmp_bit(flash_busy, 1'b1);
        access(1'b0, 1'b0, bm, a, 16'h0000, q);
        cmp_data({8'h00, q[7:0]}, 16'h004C);
        wait_busy(1'b0, 400);
        access(1'b0, 1'b0, bm, a, 16'h0000, q);
        cmp_data(q, exp_rd(a, bm));
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] q;
        logic [20:0] a;
        logic bm;
        for (int i = 0; i < 16; i++) shadow[i] = {i[3:0], 4'hA, ~i[3:0], 4'h5};
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 30; i++) begin
            seed = xs(seed);
            bm = (i < 2) ? i[0] : seed[31];
            a = (i < 2) ? 21'h1FFFFF : (bm ? seed[20:0] : {1'b0, seed[19:0]});
            access(1'b0, 1'b0, bm, a, 16'h0000, q);
            cmp_data(q, exp_rd(a, bm));
        end
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            program_check(i[0], i[0] ? seed[20:0] : {1'b0, seed[19:0]}, seed[31:16]);
        end
        a = 21'h000006;
        access(1'b1, 1'b0, 1'b0, a, 16'hC3A5, q);
        wait_busy(1'b1, 20);
        access(1'b0, 1'b1, 1'b0, a, 16'h0000, q);
        repeat (150) @(posedge clk);
        #1 cmp_bit(req_ready, 1'b0);
        program_check(1'b0, a, 16'h5A3C);
        access(1'b0, 1'b1, 1'b1, a, 16'h0000, q);
        access(1'b0, 1'b0, 1'b0, 21'h000009, 16'h0000, q);
        cmp_data(q, exp_rd(21'h000009, 1'b0));
        fork
            access(1'b0, 1'b0, 1'b1, 21'h00000B, 16'h0000, q);
            begin
                repeat (4) @(posedge clk) #1;
                ce = 1'b0;
                repeat (6) @(posedge clk) #1;
                ce = 1'b1;
            end
        join
        cmp_data(q, exp_rd(21'h00000B, 1'b1));
        cmp_bit(rd_bad, 1'b0);
        cmp_bit(wr_bad, 1'b0);
        cmp_bit(gap_bad, 1'b0);
        report_and_stop;
    end
endmodule
`default_nettype wire
